//--- src/tcc_channel.sv
`timescale 1ns/100ps
`default_nettype none
// One channel: counter, two general registers, flags
module tcc_channel
  import tcc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              standby,
  input  wire logic              up_down_ok,
  input  wire logic              count_down,
  input  wire logic              pwm_any,
  input  wire logic [7:0]        ctrl,
  input  wire logic              cap_in_a,
  input  wire logic              cap_in_b,
  input  wire logic [5:0]        wr_sel,
  input  wire logic [15:0]       wr_data,
  input  wire logic [2:0]        flag_clr,
  output logic      [15:0]       count,
  output logic      [15:0]       gen_a,
  output logic      [15:0]       gen_b,
  output logic      [2:0]        status,
  output logic                   match_a,
  output logic                   match_b,
  output logic                   capt_a
);

  logic [2:0]  div_cnt;
  logic        cap_a_q;
  logic        cap_b_q;
  logic [15:0] next_count;
  logic [2:0]  next_status;

  // Prescaler tick; ctrl[1:0] chooses clk/1, /2, /4, /8
  wire [1:0] psc     = ctrl[BIT_PSC_HI:BIT_PSC_LO];
  wire       tick    = (psc == 2'b00) ? 1'b1 :
                       (psc == 2'b01) ? (div_cnt[0] == 1'b1) :
                       (psc == 2'b10) ? (div_cnt[1:0] == 2'b11) :
                       (div_cnt == 3'b111);
  // Capture function is ignored while pwm_any is set (PWM modes, channels 3 and 4 only)
  wire       is_cap_a = ctrl[BIT_CAP_A] & ~pwm_any;
  wire       is_cap_b = ctrl[BIT_CAP_B] & ~pwm_any;
  wire [1:0] edg      = ctrl[BIT_EDGE_HI:BIT_EDGE_LO];
  wire       rise_a   = cap_in_a & ~cap_a_q;
  wire       fall_a   = ~cap_in_a & cap_a_q;
  wire       rise_b   = cap_in_b & ~cap_b_q;
  wire       fall_b   = ~cap_in_b & cap_b_q;
  wire       ev_a     = is_cap_a & ((edg == TCC_EDGE_RISE & rise_a) |
                        (edg == TCC_EDGE_FALL & fall_a) |
                        (edg == TCC_EDGE_BOTH & (rise_a | fall_a)));
  wire       ev_b     = is_cap_b & ((edg == TCC_EDGE_RISE & rise_b) |
                        (edg == TCC_EDGE_FALL & fall_b) |
                        (edg == TCC_EDGE_BOTH & (rise_b | fall_b)));
  // Continuous compare against the counter
  wire       cmp_a    = ~is_cap_a & (count == gen_a);
  wire       cmp_b    = ~is_cap_b & (count == gen_b);
  wire       hit_a    = cmp_a | ev_a;
  wire       hit_b    = cmp_b | ev_b;
  wire [1:0] clr_sel  = ctrl[BIT_CLR_HI:BIT_CLR_LO];
  wire       clr_cnt  = (clr_sel == 2'b01 & hit_a) | (clr_sel == 2'b10 & hit_b);
  wire       down     = up_down_ok & count_down;
  wire       wrap_up  = tick & ~down & (count == CNT_ALL_ONES);
  wire       wrap_dn  = tick & down & (count == CNT_ZERO);

  // Next count: CPU write beats clearing, clearing beats counting
  always_comb begin
    next_count = count;
    if (clr_cnt) begin
      next_count = CNT_ZERO;
    end else if (tick) begin
      next_count = down ? count - 16'h0001 : count + 16'h0001;
    end
    if (wr_sel[1]) begin
      next_count[15:8] = wr_data[15:8];
    end
    if (wr_sel[0]) begin
      next_count[7:0] = wr_data[7:0];
    end
  end

  // Hardware set wins over software clear
  always_comb begin
    next_status = status & ~flag_clr;
    if (wrap_up | wrap_dn) begin
      next_status[BIT_WRAP] = 1'b1;
    end
    if (hit_a) begin
      next_status[BIT_FLAG_A] = 1'b1;
    end
    if (hit_b) begin
      next_status[BIT_FLAG_B] = 1'b1;
    end
  end

  // Counter, flags and prescaler
  always_ff @(posedge clk) begin
    if (!nrst || standby) begin
      count   <= RST_COUNT;
      status  <= 3'b000;
      div_cnt <= 3'b000;
      cap_a_q <= 1'b0;
      cap_b_q <= 1'b0;
      match_a <= 1'b0;
      match_b <= 1'b0;
      capt_a  <= 1'b0;
    end else begin
      count   <= next_count;
      status  <= next_status;
      div_cnt <= div_cnt + 3'b001;
      cap_a_q <= cap_in_a;
      cap_b_q <= cap_in_b;
      match_a <= cmp_a;
      match_b <= cmp_b;
      capt_a  <= ev_a;
    end
  end

  // General registers: capture beats a CPU write in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst || standby) begin
      gen_a <= RST_GEN;
      gen_b <= RST_GEN;
    end else begin
      if (ev_a) begin
        gen_a <= count;
      end else begin
        if (wr_sel[3]) gen_a[15:8] <= wr_data[15:8];
        if (wr_sel[2]) gen_a[7:0]  <= wr_data[7:0];
      end
      if (ev_b) begin
        gen_b <= count;
      end else begin
        if (wr_sel[5]) gen_b[15:8] <= wr_data[15:8];
        if (wr_sel[4]) gen_b[7:0]  <= wr_data[7:0];
      end
    end
  end

endmodule
`default_nettype wire

//--- src/tcc_pkg.sv
package tcc_pkg;

  // Geometry
  localparam int NUM_CH       = 5;
  localparam int CNT_W        = 16;
  localparam int ADDR_W       = 6;

  // Register byte addresses (word registers take two bytes, high byte even)
  localparam logic [5:0] OFS_OUT_CTRL   = 6'h00;
  localparam logic [5:0] OFS_OUT_ENABLE = 6'h01;
  localparam logic [5:0] OFS_CH_BASE    = 6'h04;
  localparam logic [5:0] OFS_CH_STRIDE  = 6'h08;
  localparam logic [5:0] OFS_CH_COUNT   = 6'h00;
  localparam logic [5:0] OFS_CH_GEN_A   = 6'h02;
  localparam logic [5:0] OFS_CH_GEN_B   = 6'h04;
  localparam logic [5:0] OFS_CH_CTRL    = 6'h06;
  localparam logic [5:0] OFS_CH_STATUS  = 6'h07;

  // Output control field positions
  localparam int BIT_TRIG_DIS   = 4;
  localparam int BIT_LEVEL_FOUR = 1;
  localparam int BIT_LEVEL_THREE = 0;
  localparam logic [7:0] OUT_CTRL_RSVD  = 8'hEC;
  localparam logic [7:0] OUT_ENA_RSVD   = 8'hC0;

  // Reset values and counter limits
  localparam logic [7:0]  RST_OUT_CTRL  = 8'hFF;
  localparam logic [7:0]  RST_OUT_ENA   = 8'hFF;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [15:0] RST_GEN       = 16'hFFFF;
  localparam logic [7:0]  RST_CH_CTRL   = 8'h00;
  localparam logic [15:0] CNT_ALL_ONES  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;

  // Channel control fields: [7:6] clear source, [5] capture A, [4] capture B,
  // [3:2] capture edge, [1:0] prescale select
  localparam int BIT_CLR_HI   = 7;
  localparam int BIT_CLR_LO   = 6;
  localparam int BIT_CAP_A    = 5;
  localparam int BIT_CAP_B    = 4;
  localparam int BIT_EDGE_HI  = 3;
  localparam int BIT_EDGE_LO  = 2;
  localparam int BIT_PSC_HI   = 1;
  localparam int BIT_PSC_LO   = 0;

  // Status fields
  localparam int BIT_WRAP   = 2;
  localparam int BIT_FLAG_B = 1;
  localparam int BIT_FLAG_A = 0;

  // Prescale dividers in clock cycles
  localparam int DIV_1 = 1;
  localparam int DIV_2 = 2;
  localparam int DIV_4 = 4;
  localparam int DIV_8 = 8;

  typedef enum logic [1:0] {
    TCC_MODE_NORMAL = 2'b00,
    TCC_MODE_PHASE  = 2'b01,
    TCC_MODE_CPWM   = 2'b11,
    TCC_MODE_RSPWM  = 2'b10
  } tcc_mode_type;

  typedef enum logic [1:0] {
    TCC_EDGE_RISE = 2'b00,
    TCC_EDGE_FALL = 2'b01,
    TCC_EDGE_BOTH = 2'b11,
    TCC_EDGE_NONE = 2'b10
  } tcc_edge_type;

endpackage

//--- src/tcc_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Trip and level bits act only in PWM modes
// - Output control resets to all ones
// - Reserved control bits ignore writes, read one
// - Channel 1 capture A clears output enables
// - Trip disabled when trigger disable is one
// - Level four zero inverts ch3 A, ch4 A/B
// - Level three zero inverts ch3 B, complements
// - Five 16-bit counters; channels 0, 1 count up
// - Channel 2 counts down only in phase mode
// - Channels 3, 4 count down only complementary PWM
// - Counters advance on selected prescaler ticks
// - Counter clears on register A or B hit
// - Upward wrap sets the wrap flag
// - Downward wrap sets the wrap flag
// - Counters readable and writable by word or byte
// - Counters reset to zero
// - Two general registers per channel, compare or capture
// - Compare equality sets match flag, drives output
// - Capture stores count on chosen edge, sets flag
// - Capture selection ignored in PWM modes on channels 3, 4
// - General registers readable and writable, word or byte
// - General registers reset to all ones, compare
// - Cleared enable bit releases that pin
// - Output enables reset to all ones
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  standby,
  input  wire logic [ADDR_W-1:0]     bus_addr,
  input  wire logic                  bus_rd,
  input  wire logic                  bus_wr,
  input  wire logic [1:0]            bus_be,
  input  wire logic [15:0]           bus_wdata,
  output logic      [15:0]           bus_rdata,
  input  wire logic [1:0]            mode_sel,
  input  wire logic                  count_down,
  input  wire logic [NUM_CH-1:0]     cap_pin_a,
  input  wire logic [NUM_CH-1:0]     cap_pin_b,
  output logic                       ch3_pin_a,
  output logic                       ch3_pin_b,
  output logic                       ch4_pin_a,
  output logic                       ch4_pin_b,
  output logic                       ch4_compl_pin_a,
  output logic                       ch4_compl_pin_b,
  output logic      [5:0]            pin_oe,
  output logic      [NUM_CH-1:0]     match_a_pulse,
  output logic      [NUM_CH-1:0]     match_b_pulse
);

  logic [7:0]  output_trip_level_ctrl;
  logic [7:0]  output_master_enable_reg;
  logic [7:0]  counter_control_reg [NUM_CH];
  logic [15:0] channel_count_value [NUM_CH];
  logic [15:0] general_match_capture_a [NUM_CH];
  logic [15:0] general_match_capture_b [NUM_CH];
  logic [2:0]  channel_status_reg [NUM_CH];
  logic [NUM_CH-1:0] ch_match_a;
  logic [NUM_CH-1:0] ch_match_b;
  logic [NUM_CH-1:0] ch_capt_a;
  logic [NUM_CH-1:0] pa_s1;
  logic [NUM_CH-1:0] pa_s2;
  logic [NUM_CH-1:0] pb_s1;
  logic [NUM_CH-1:0] pb_s2;
  logic [1:0]  mode_s1;
  logic [1:0]  mode_s2;
  logic        dir_s1;
  logic        dir_s2;
  logic [5:0]  pwm_wave;
  logic [7:0]  next_enable;
  logic [15:0] next_rdata;

  // Channel offset within its window
  function automatic logic [5:0] ch_ofs(input logic [5:0] a);
    ch_ofs = (a - OFS_CH_BASE) & (OFS_CH_STRIDE - 6'h01);
  endfunction

  // Channel index of a byte address, NUM_CH when none
  function automatic logic [2:0] ch_idx(input logic [5:0] a);
    logic [5:0] rel;
    rel = a - OFS_CH_BASE;
    if (a < OFS_CH_BASE || rel >= 6'(NUM_CH * 8)) ch_idx = 3'(NUM_CH);
    else ch_idx = rel[5:3];
  endfunction

  wire [2:0] wr_ch   = ch_idx(bus_addr);
  wire [5:0] wr_ofs  = ch_ofs(bus_addr);
  wire       pwm_cm  = (mode_s2 == TCC_MODE_CPWM);
  wire       pwm_rs  = (mode_s2 == TCC_MODE_RSPWM);
  wire       pwm_on  = pwm_cm | pwm_rs;
  wire       trip_en = pwm_on & ~output_trip_level_ctrl[BIT_TRIG_DIS];
  wire       trip    = trip_en & ch_capt_a[1];
  wire       inv4    = pwm_on & ~output_trip_level_ctrl[BIT_LEVEL_FOUR];
  wire       inv3    = pwm_on & ~output_trip_level_ctrl[BIT_LEVEL_THREE];
  wire       ctl_wr  = bus_wr & (bus_addr == OFS_OUT_CTRL);
  wire       ena_wr  = bus_wr & (bus_addr == OFS_OUT_ENABLE);

  // Mode and direction come from another block; double-flop them
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_s1 <= 2'b00;
      mode_s2 <= 2'b00;
      dir_s1  <= 1'b0;
      dir_s2  <= 1'b0;
      pa_s1   <= '0;
      pa_s2   <= '0;
      pb_s1   <= '0;
      pb_s2   <= '0;
    end else begin
      mode_s1 <= mode_sel;
      mode_s2 <= mode_s1;
      dir_s1  <= count_down;
      dir_s2  <= dir_s1;
      pa_s1   <= cap_pin_a;
      pa_s2   <= pa_s1;
      pb_s1   <= cap_pin_b;
      pb_s2   <= pb_s1;
    end
  end

  // Channels
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      logic        updn_ok;
      logic        ch_pwm;
      logic [5:0]  wsel;
      logic [2:0]  fclr;
      logic        hit;
      assign updn_ok = (g == 2) ? (mode_s2 == TCC_MODE_PHASE) :
                       (g >= 3) ? pwm_cm : 1'b0;
      assign ch_pwm  = (g >= 3) & pwm_on;
      assign hit     = bus_wr & (wr_ch == 3'(g));
      assign wsel[1] = hit & (wr_ofs == OFS_CH_COUNT) & bus_be[1];
      assign wsel[0] = hit & (wr_ofs == OFS_CH_COUNT) & bus_be[0];
      assign wsel[3] = hit & (wr_ofs == OFS_CH_GEN_A) & bus_be[1];
      assign wsel[2] = hit & (wr_ofs == OFS_CH_GEN_A) & bus_be[0];
      assign wsel[5] = hit & (wr_ofs == OFS_CH_GEN_B) & bus_be[1];
      assign wsel[4] = hit & (wr_ofs == OFS_CH_GEN_B) & bus_be[0];
      // Writing one to a status bit clears it
      assign fclr    = (hit & (wr_ofs == OFS_CH_CTRL) & bus_be[0]) ?
                       bus_wdata[2:0] : 3'b000;

      tcc_channel u_ch (
        .clk        (clk),
        .nrst       (nrst),
        .standby    (standby),
        .up_down_ok (updn_ok),
        .count_down (dir_s2),
        .pwm_any    (ch_pwm),
        .ctrl       (counter_control_reg[g]),
        .cap_in_a   (pa_s2[g]),
        .cap_in_b   (pb_s2[g]),
        .wr_sel     (wsel),
        .wr_data    (bus_wdata),
        .flag_clr   (fclr),
        .count      (channel_count_value[g]),
        .gen_a      (general_match_capture_a[g]),
        .gen_b      (general_match_capture_b[g]),
        .status     (channel_status_reg[g]),
        .match_a    (ch_match_a[g]),
        .match_b    (ch_match_b[g]),
        .capt_a     (ch_capt_a[g])
      );

      // Control byte rides the high lane of the shared control/status word
      always_ff @(posedge clk) begin
        if (!nrst || standby) begin
          counter_control_reg[g] <= RST_CH_CTRL;
        end else if (hit && wr_ofs == OFS_CH_CTRL && bus_be[1]) begin
          counter_control_reg[g] <= bus_wdata[15:8];
        end
      end
    end
  endgenerate

  // Trip clears enables 5..0; it wins over a CPU write in the same cycle
  always_comb begin
    next_enable = output_master_enable_reg;
    if (ena_wr && bus_be[0]) begin
      next_enable = bus_wdata[7:0] | OUT_ENA_RSVD;
    end
    if (trip) begin
      next_enable = OUT_ENA_RSVD;
    end
  end

  // Output control and enable registers
  always_ff @(posedge clk) begin
    if (!nrst || standby) begin
      output_trip_level_ctrl   <= RST_OUT_CTRL;
      output_master_enable_reg <= RST_OUT_ENA;
    end else begin
      if (ctl_wr && bus_be[0]) begin
        output_trip_level_ctrl <= bus_wdata[7:0] | OUT_CTRL_RSVD;
      end
      output_master_enable_reg <= next_enable;
    end
  end

  // Compare waveform per pin, A pins toggled on A match, B pins toggled on B match
  always_ff @(posedge clk) begin
    if (!nrst || standby) begin
      pwm_wave <= 6'b000000;
    end else begin
      pwm_wave[0] <= ch_match_a[3] ? ~pwm_wave[0] : pwm_wave[0];
      pwm_wave[1] <= ch_match_b[3] ? ~pwm_wave[1] : pwm_wave[1];
      pwm_wave[2] <= ch_match_a[4] ? ~pwm_wave[2] : pwm_wave[2];
      pwm_wave[3] <= ch_match_b[4] ? ~pwm_wave[3] : pwm_wave[3];
      pwm_wave[4] <= ch_match_a[4] ? pwm_wave[2] : pwm_wave[4];
      pwm_wave[5] <= ch_match_b[4] ? pwm_wave[3] : pwm_wave[5];
    end
  end

  // Pin drivers with level inversion and master enables
  always_ff @(posedge clk) begin
    if (!nrst || standby) begin
      ch3_pin_a       <= 1'b0;
      ch3_pin_b       <= 1'b0;
      ch4_pin_a       <= 1'b0;
      ch4_pin_b       <= 1'b0;
      ch4_compl_pin_a <= 1'b0;
      ch4_compl_pin_b <= 1'b0;
      pin_oe          <= 6'b000000;
      match_a_pulse   <= '0;
      match_b_pulse   <= '0;
    end else begin
      ch3_pin_a       <= pwm_wave[0] ^ inv4;
      ch4_pin_a       <= pwm_wave[2] ^ inv4;
      ch4_pin_b       <= pwm_wave[3] ^ inv4;
      ch3_pin_b       <= pwm_wave[1] ^ inv3;
      ch4_compl_pin_a <= ~pwm_wave[2] ^ inv3;
      ch4_compl_pin_b <= ~pwm_wave[3] ^ inv3;
      // Drive only in PWM output modes and while enabled
      pin_oe          <= output_master_enable_reg[5:0] & {6{pwm_on}};
      match_a_pulse   <= ch_match_a;
      match_b_pulse   <= ch_match_b;
    end
  end

  // Read mux
  wire [2:0] rd_ch  = ch_idx(bus_addr);
  wire [5:0] rd_ofs = ch_ofs(bus_addr);
  always_comb begin
    next_rdata = 16'h0000;
    if (bus_addr == OFS_OUT_CTRL) begin
      next_rdata = {8'h00, output_trip_level_ctrl};
    end else if (bus_addr == OFS_OUT_ENABLE) begin
      next_rdata = {8'h00, output_master_enable_reg};
    end else if (rd_ch < 3'(NUM_CH)) begin
      case (rd_ofs)
        OFS_CH_COUNT: next_rdata = channel_count_value[rd_ch];
        OFS_CH_GEN_A: next_rdata = general_match_capture_a[rd_ch];
        OFS_CH_GEN_B: next_rdata = general_match_capture_b[rd_ch];
        OFS_CH_CTRL:  next_rdata = {counter_control_reg[rd_ch],
                                    5'b00000, channel_status_reg[rd_ch]};
        default:      next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tcc_pkg::*;
  logic clk, nrst, standby, count_down;
  logic [1:0] mode_sel;
  logic [4:0] cap_a, ma, mb;
  logic [5:0] addr, oe, pins, p1;
  logic rd, wr;
  logic [1:0] be;
  logic [15:0] wdata, rdata, v, w;
  int error_cnt, check_count, cyc, hits, hitb;
  tcc_cpu_model cpu (.clk(clk), .bus_addr(addr), .bus_rd(rd), .bus_wr(wr), .bus_be(be),
    .bus_wdata(wdata), .bus_rdata(rdata));
  tcc_timer DUT (.clk(clk), .nrst(nrst), .standby(standby), .bus_addr(addr),
    .bus_rd(rd), .bus_wr(wr), .bus_be(be), .bus_wdata(wdata), .bus_rdata(rdata),
    .mode_sel(mode_sel), .count_down(count_down), .cap_pin_a(cap_a),
    .cap_pin_b(cap_a), .ch3_pin_a(pins[5]), .ch3_pin_b(pins[4]), .ch4_pin_a(pins[3]),
    .ch4_pin_b(pins[2]), .ch4_compl_pin_a(pins[1]), .ch4_compl_pin_b(pins[0]),
    .pin_oe(oe), .match_a_pulse(ma), .match_b_pulse(mb));
  initial begin
    {clk, nrst, standby, count_down, mode_sel, cap_a} = '0;
  end
  always #2 clk = ~clk;
  // Watchdog and compare-pulse tally
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ma[0] === 1'b1) hits <= hits + 1;
    if (mb[0] === 1'b1) hitb <= hitb + 1;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end
  function automatic logic [5:0] ca(int ch, logic [5:0] ofs);
    return 6'(OFS_CH_BASE + OFS_CH_STRIDE * ch + ofs);
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g, logic [15:0] m);
    check_count++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rng(string n, logic [15:0] lo, logic [15:0] hi, logic [15:0] g);
    check_count++;
    if ($isunknown(g) || g < lo || g > hi) begin
      error_cnt++;
      $display("[FAIL] %s exp %h..%h got %h", n, lo, hi, g);
    end
  endtask
  task automatic rc(string n, logic [5:0] a, logic [15:0] e, logic [15:0] m);
    cpu.rd(a, v);
    chk(n, e, v, m);
  endtask
  task automatic set_mode(logic [1:0] m, logic d);
    @(posedge clk);
    mode_sel <= m;
    count_down <= d;
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse_cap();
    @(posedge clk);
    cap_a[1] <= 1'b1;
    repeat (4) @(posedge clk);
    cap_a[1] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // Direction seen over two reads a few cycles apart
  task automatic dir(int ch, bit down);
    cpu.wr(ca(ch, OFS_CH_COUNT), 2'b11, 16'h8000);
    cpu.rd(ca(ch, OFS_CH_COUNT), v);
    cpu.rd(ca(ch, OFS_CH_COUNT), w);
    if (down) rng("count down", v - 16'd20, v - 16'd1, w);
    else rng("count up", v + 16'd1, v + 16'd20, w);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rc("ctrl reset", OFS_OUT_CTRL, 16'h00FF, 16'h00FF);
    rc("enable reset", OFS_OUT_ENABLE, 16'h00FF, 16'h00FF);
    cpu.wr(OFS_OUT_CTRL, 2'b01, 16'h0000);
    rc("ctrl reserved", OFS_OUT_CTRL, 16'h00EC, 16'h00FF);
    cpu.wr(OFS_OUT_CTRL, 2'b01, 16'h00FF);
    // Byte lanes on a general register and a counter
    cpu.wr(ca(0, OFS_CH_GEN_A), 2'b11, 16'h1234);
    rc("gen word", ca(0, OFS_CH_GEN_A), 16'h1234, 16'hFFFF);
    cpu.wr(ca(0, OFS_CH_GEN_A), 2'b10, 16'hAB00);
    cpu.wr(ca(0, OFS_CH_GEN_A), 2'b01, 16'h00CD);
    rc("gen bytes", ca(0, OFS_CH_GEN_A), 16'hABCD, 16'hFFFF);
    cpu.wr(ca(1, OFS_CH_COUNT), 2'b10, 16'h5500);
    rc("count high byte", ca(1, OFS_CH_COUNT), 16'h5500, 16'hFF00);
    cpu.wr(ca(0, OFS_CH_COUNT), 2'b11, 16'h0100);
    cpu.rd(ca(0, OFS_CH_COUNT), v);
    rng("count word", 16'h0100, 16'h0104, v);
    // All four prescale settings
    for (int p = 0; p < 4; p++) begin
      cpu.wr(ca(0, OFS_CH_CTRL), 2'b10, {6'h00, 2'(p), 8'h00});
      cpu.wr(ca(0, OFS_CH_COUNT), 2'b11, 16'h0000);
      repeat (64) @(posedge clk);
      cpu.rd(ca(0, OFS_CH_COUNT), v);
      rng("prescale", 16'(60 >> p), 16'((72 >> p) + 1), v);
    end
    // Clear on a register A hit; flag and pulse follow
    cpu.wr(ca(0, OFS_CH_CTRL), 2'b10, 16'h4000);
    cpu.wr(ca(0, OFS_CH_GEN_A), 2'b11, 16'h0040);
    cpu.wr(ca(0, OFS_CH_CTRL), 2'b01, 16'h0007);
    cpu.wr(ca(0, OFS_CH_COUNT), 2'b11, 16'h0000);
    repeat (200) @(posedge clk);
    cpu.rd(ca(0, OFS_CH_COUNT), v);
    rng("count cleared", 16'h0000, 16'h0040, v);
    rc("match flag", ca(0, OFS_CH_CTRL), 16'h0001, 16'h0001);
    rng("match pulses", 16'd2, 16'hFFFF, 16'(hits));
    cpu.wr(ca(0, OFS_CH_CTRL), 2'b11, 16'h0007);
    cpu.wr(ca(0, OFS_CH_COUNT), 2'b11, 16'hFFF0);
    repeat (40) @(posedge clk);
    rc("wrap up", ca(0, OFS_CH_CTRL), 16'h0004, 16'h0004);
    // Clear on a register B hit, counter still below it
    cpu.wr(ca(0, OFS_CH_GEN_B), 2'b11, 16'h0050);
    rc("gen b word", ca(0, OFS_CH_GEN_B), 16'h0050, 16'hFFFF);
    cpu.wr(ca(0, OFS_CH_CTRL), 2'b11, 16'h8007);
    repeat (200) @(posedge clk);
    cpu.rd(ca(0, OFS_CH_COUNT), v);
    rng("count cleared b", 16'h0000, 16'h0050, v);
    rc("match flag b", ca(0, OFS_CH_CTRL), 16'h0002, 16'h0002);
    rng("match b pulses", 16'd2, 16'hFFFF, 16'(hitb));
    // Count direction per mode
    set_mode(TCC_MODE_PHASE, 1'b1);
    dir(2, 1'b1);
    dir(0, 1'b0);
    dir(3, 1'b0);
    cpu.wr(ca(2, OFS_CH_CTRL), 2'b01, 16'h0007);
    cpu.wr(ca(2, OFS_CH_COUNT), 2'b11, 16'h0010);
    repeat (40) @(posedge clk);
    rc("wrap down", ca(2, OFS_CH_CTRL), 16'h0004, 16'h0004);
    set_mode(TCC_MODE_CPWM, 1'b1);
    dir(3, 1'b1);
    dir(4, 1'b1);
    dir(2, 1'b0);
    dir(1, 1'b0);
    // Level select flips the six pins, counters parked far from any match
    set_mode(TCC_MODE_CPWM, 1'b0);
    chk("pins enabled", 16'h003F, {10'h000, oe}, 16'h003F);
    cpu.wr(ca(3, OFS_CH_COUNT), 2'b11, 16'h0100);
    cpu.wr(ca(4, OFS_CH_COUNT), 2'b11, 16'h0100);
    p1 = pins;
    cpu.wr(OFS_OUT_CTRL, 2'b01, 16'h00FC);
    repeat (4) @(posedge clk);
    chk("levels", {10'h000, ~p1}, {10'h000, pins}, 16'h003F);
    cpu.wr(OFS_OUT_CTRL, 2'b01, 16'h00FF);
    // Channel 1 capture as trip source
    cpu.wr(ca(1, OFS_CH_CTRL), 2'b10, 16'h3000);
    cpu.wr(ca(1, OFS_CH_COUNT), 2'b11, 16'h1000);
    pulse_cap();
    rc("no trip", OFS_OUT_ENABLE, 16'h00FF, 16'h00FF);
    cpu.rd(ca(1, OFS_CH_GEN_A), v);
    rng("capture", 16'h1000, 16'h1040, v);
    cpu.rd(ca(1, OFS_CH_GEN_B), v);
    rng("capture b", 16'h1000, 16'h1040, v);
    rc("capture flag", ca(1, OFS_CH_CTRL), 16'h0001, 16'h0001);
    cpu.wr(OFS_OUT_CTRL, 2'b01, 16'h00EF);
    pulse_cap();
    rc("trip", OFS_OUT_ENABLE, 16'h00C0, 16'h00FF);
    chk("pins off", 16'h0000, {10'h000, oe}, 16'h003F);
    set_mode(TCC_MODE_NORMAL, 1'b0);
    cpu.wr(OFS_OUT_ENABLE, 2'b01, 16'h00FF);
    pulse_cap();
    rc("no trip plain", OFS_OUT_ENABLE, 16'h00FF, 16'h00FF);
    // Standby re-initialises all but the synchronisers and read data
    for (int c = 0; c < 5; c++) begin
      cpu.wr(ca(c, OFS_CH_GEN_A), 2'b11, 16'h1234);
      cpu.wr(ca(c, OFS_CH_COUNT), 2'b11, 16'h7000);
    end
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rc("ctrl standby", OFS_OUT_CTRL, 16'h00FF, 16'h00FF);
    for (int c = 0; c < 5; c++) begin
      cpu.rd(ca(c, OFS_CH_COUNT), v);
      rng("count standby", 16'h0000, 16'h0080, v);
      rc("gen standby", ca(c, OFS_CH_GEN_A), 16'hFFFF, 16'hFFFF);
    end
    close_out();
  end
endmodule
`default_nettype wire

//--- tb/tcc_checker.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level watch of the timer core
module tcc_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        standby,
  input wire logic [5:0]  bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic [1:0]  bus_be,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic [1:0]  mode_sel,
  input wire logic [5:0]  pin_oe,
  input wire logic [4:0]  match_a_pulse
);
  import tcc_pkg::*;
  localparam logic [5:0] A_CNT = OFS_CH_BASE + OFS_CH_COUNT;
  localparam logic [5:0] A_GEN = OFS_CH_BASE + OFS_CH_GEN_A;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Word write, idle cycle, read back of channel 0
  sequence cnt_wr_rd;
    bus_wr && bus_be == 2'b11 && bus_addr == A_CNT ##2 bus_rd && bus_addr == A_CNT;
  endsequence
  sequence gen_wr_rd;
    bus_wr && bus_be == 2'b11 && bus_addr == A_GEN ##2 bus_rd && bus_addr == A_GEN;
  endsequence
  // Mode held in a PWM or a plain mode long enough to pass the synchroniser
  sequence pwm_steady;
    mode_sel[1] [*4];
  endsequence
  sequence plain_steady;
    !mode_sel[1] [*4];
  endsequence
  rst_quiet_a: assert property ($rose(nrst) |-> pin_oe == 6'h00 && match_a_pulse == 5'h00)
    else $error("outputs active after reset");
  rdata_holds_a: assert property (!bus_rd && !standby |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  ctrl_rsvd_a: assert property (bus_rd && bus_addr == OFS_OUT_CTRL
    |=> (bus_rdata[7:0] & OUT_CTRL_RSVD) == OUT_CTRL_RSVD) else $error("reserved bit read 0");
  ena_rsvd_a: assert property (bus_rd && bus_addr == OFS_OUT_ENABLE
    |=> (bus_rdata[7:0] & OUT_ENA_RSVD) == OUT_ENA_RSVD) else $error("enable top bit read 0");
  cnt_readback_a: assert property (cnt_wr_rd |=> bus_rdata - $past(bus_wdata, 3) <= 16'h0003)
    else $error("count read back far from written value");
  gen_readback_a: assert property (gen_wr_rd |=> bus_rdata == $past(bus_wdata, 3))
    else $error("general register read back differs");
  oe_plain_off_a: assert property (plain_steady |=> pin_oe == 6'h00)
    else $error("pin driven outside PWM modes");
  oe_mirror_a: assert property (pwm_steady ##0 bus_rd && bus_addr == OFS_OUT_ENABLE
    |=> bus_rdata[5:0] == pin_oe) else $error("pin enables differ from register");
endmodule

bind tcc_timer tcc_checker chk (.clk(clk), .nrst(nrst), .standby(standby),
  .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_be(bus_be),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .mode_sel(mode_sel),
  .pin_oe(pin_oe), .match_a_pulse(match_a_pulse));
`default_nettype wire

//--- tb/tcc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// Bus master on the CPU side; released address and data show the inverse, byte enables keep their value
module tcc_cpu_model (
  input  wire logic        clk,
  output logic      [5:0]  bus_addr,
  output logic             bus_rd,
  output logic             bus_wr,
  output logic      [1:0]  bus_be,
  output logic      [15:0] bus_wdata,
  input  wire logic [15:0] bus_rdata
);
  import tcc_pkg::*;
  initial begin
    bus_addr = 6'h3F;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_be = 2'b00;
    bus_wdata = 16'h0000;
  end
  // One-cycle write strobe, taken at the next edge
  task automatic wr(input logic [5:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_be <= be;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask
  // Data lands one edge after the strobe and then stands
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    @(posedge clk);
    d = bus_rdata;
  endtask
endmodule
`default_nettype wire
